// ### shlpc_drive_model.sv
// Drive model for the host link power control block.
// Assumes the bench pulses want for one cycle per request.
`timescale 1ns/10ps
`default_nettype none
module shlpc_drive_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [2:0] want,
    input wire logic nak_mode,
    input wire logic send_xrdy,
    input wire logic send_rrdy,
    input wire logic send_pmack,
    output logic rx_xrdy,
    output logic rx_pmreq_partial,
    output logic rx_pmreq_slumber,
    output logic pm_nak
);
    // ****************
    // Request holding
    // ****************
    logic [2:0] held;
    logic [2:0] next_held;
    // A request stands until the host answers with any primitive
    always_comb begin
        next_held = want | held;
        if (send_xrdy || send_rrdy || send_pmack) begin
            next_held = 3'h0; // give up on X_RDY, R_RDY or PMACK
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            held <= 3'h0;
        end else begin
            held <= next_held;
        end
    end
    // Order is xrdy, partial, slumber
    assign {rx_xrdy, rx_pmreq_partial, rx_pmreq_slumber} = want | held;
    assign pm_nak = nak_mode & send_pmack;
endmodule // shlpc_drive_model
`default_nettype wire

// ### shlpc_pkg.sv
// Package for the host link power control block: constants, states, structs.
// Assumes a single 100 MHz controller clock and active-low async reset.
`default_nettype none
package shlpc_pkg;
    // Clock period in picoseconds
    localparam int CLK_PS = 10000;
    // Settle time between PHY power-down steps, in ns
    localparam int STEP_NS = 100;
    localparam int STEP_CYC = (STEP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam logic [7:0] STEP_CNT = 8'(STEP_CYC);
    // Coalescing counter width and reset value
    localparam int CCC_W = 8;
    localparam logic [7:0] CCC_RST = 8'h00;
    // PRD byte counter width and reset value
    localparam int PRD_W = 16;
    localparam logic [15:0] PRD_RST = 16'h0000;

    // Link states, one-hot
    typedef enum logic [5:0] {
        SHLPC_L_IDLE = 6'b00_0001,
        SHLPC_L_SEND_XRDY = 6'b00_0010,
        SHLPC_L_SEND_RRDY = 6'b00_0100,
        SHLPC_L_PM_ACK = 6'b00_1000,
        SHLPC_L_PARTIAL = 6'b01_0000,
        SHLPC_L_SLUMBER = 6'b10_0000
    } shlpc_link_t;

    // PHY power-down sequence states, one-hot
    typedef enum logic [5:0] {
        SHLPC_P_ON = 6'b00_0001,
        SHLPC_P_RX_OFF = 6'b00_0010,
        SHLPC_P_TX_OFF = 6'b00_0100,
        SHLPC_P_MPLL_OFF = 6'b00_1000,
        SHLPC_P_CK_OFF = 6'b01_0000,
        SHLPC_P_DONE = 6'b10_0000
    } shlpc_pwr_t;

    // Events seen from the link side
    typedef struct packed {
        logic tx_data_rdy;
        logic rx_xrdy;
        logic rx_pmreq_partial;
        logic rx_pmreq_slumber;
        logic soft_reset;
    } shlpc_link_ev_t;

    // PHY power-control outputs
    typedef struct packed {
        logic rx_pd;
        logic tx_pd;
        logic mpll_pd;
        logic refclk_off_control;
    } shlpc_phy_pd_t;
endpackage : shlpc_pkg
`default_nettype wire

// ### shlpc_pulse1.sv
// One-cycle pulse shaper: a level that stays high yields a single pulse.
// Assumes a level input synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module shlpc_pulse1 (
    input wire logic clk,
    input wire logic rstn,
    input wire logic level,
    output logic pulse
);
    logic seen;
    logic next_seen;

    // ***********************************
    // Edge detect on the incoming level
    // ***********************************
    always_comb begin
        next_seen = level;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seen <= 1'b0;
        end else begin
            seen <= next_seen;
        end
    end

    assign pulse = level & ~seen; // Stretch-proof: only the rising edge
endmodule // shlpc_pulse1
`default_nettype wire

// ### shlpc_top.sv
// Host link power-mode control: link handshake, power requests, CCC,
// PRD-done interrupt, write response pulse and PHY power-down ordering.
// Assumes inputs synchronous to clk; software does resume waits itself.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - TX data colliding with drive Slumber request: ignore it, send X_RDY.
// - After good Partial negotiation only partial output; never slumber.
// - CCC increment colliding with clear leaves 0, no extra interrupt.
// - Descriptor-processed interrupt only after whole PRD is transferred.
// - Write response lasts exactly one cycle, even during FIFO clear.
// - Soft reset with incoming FIS still answers X_RDY with R_RDY.
// - Soft reset before drive power request: go idle, no SYNC wait.
// - PHY power-down sequence starts only from Slumber.
// - Power down RX, then TX, then MPLL, then refclk off.
module shlpc_top (
    input wire logic clk,
    input wire logic rstn,
    input wire shlpc_pkg::shlpc_link_ev_t link_ev,
    input wire logic pm_nak,
    input wire logic sw_req_suspend,
    input wire logic ccc_enable,
    input wire logic [7:0] ccc_threshold,
    input wire logic cmd_complete,
    input wire logic prd_start,
    input wire logic [15:0] prd_bytes,
    input wire logic data_fis_done,
    input wire logic [15:0] data_fis_bytes,
    input wire logic wrresp_raw,
    output logic send_xrdy,
    output logic send_rrdy,
    output logic send_pmack,
    output logic phy_partial_req,
    output logic phy_slumber_req,
    output logic [5:0] link_state,
    output logic ccc_irq,
    output logic [7:0] ccc_count,
    output logic dps_irq,
    output logic wrresp,
    output shlpc_pkg::shlpc_phy_pd_t phy_pd,
    output logic pd_done
);
    shlpc_pkg::shlpc_link_t lst;
    shlpc_pkg::shlpc_link_t next_lst;
    logic pm_partial;
    logic next_pm_partial;

    // ***********************************
    // Link state machine
    // ***********************************
    // The requested mode is latched once; no stale flag survives a collision.
    always_comb begin
        next_lst = lst;
        next_pm_partial = pm_partial;
        case (lst)
            shlpc_pkg::SHLPC_L_IDLE: begin
                if (link_ev.rx_xrdy) begin
                    next_lst = shlpc_pkg::SHLPC_L_SEND_RRDY;
                end else if (link_ev.soft_reset) begin
                    next_lst = shlpc_pkg::SHLPC_L_IDLE;
                end else if (link_ev.tx_data_rdy) begin
                    next_lst = shlpc_pkg::SHLPC_L_SEND_XRDY;
                end else if (link_ev.rx_pmreq_partial) begin
                    next_lst = shlpc_pkg::SHLPC_L_PM_ACK;
                    next_pm_partial = 1'b1;
                end else if (link_ev.rx_pmreq_slumber) begin
                    next_lst = shlpc_pkg::SHLPC_L_PM_ACK;
                    next_pm_partial = 1'b0;
                end
            end
            shlpc_pkg::SHLPC_L_SEND_XRDY: begin
                next_lst = shlpc_pkg::SHLPC_L_IDLE;
            end
            shlpc_pkg::SHLPC_L_SEND_RRDY: begin
                next_lst = shlpc_pkg::SHLPC_L_IDLE;
            end
            shlpc_pkg::SHLPC_L_PM_ACK: begin
                // Soft reset returns straight to idle without awaiting SYNC
                if (pm_nak || link_ev.soft_reset) begin
                    next_lst = shlpc_pkg::SHLPC_L_IDLE;
                end else if (pm_partial) begin
                    next_lst = shlpc_pkg::SHLPC_L_PARTIAL;
                end else begin
                    next_lst = shlpc_pkg::SHLPC_L_SLUMBER;
                end
            end
            shlpc_pkg::SHLPC_L_PARTIAL,
            shlpc_pkg::SHLPC_L_SLUMBER: begin
                if (link_ev.rx_xrdy || link_ev.tx_data_rdy
                        || link_ev.soft_reset) begin
                    next_lst = shlpc_pkg::SHLPC_L_IDLE;
                end
            end
            default: begin
                next_lst = shlpc_pkg::SHLPC_L_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lst <= shlpc_pkg::SHLPC_L_IDLE;
            pm_partial <= 1'b0;
        end else begin
            lst <= next_lst;
            pm_partial <= next_pm_partial;
        end
    end

    // Outputs decoded from one state, so both modes can never be set
    assign send_xrdy = (lst == shlpc_pkg::SHLPC_L_SEND_XRDY);
    assign send_rrdy = (lst == shlpc_pkg::SHLPC_L_SEND_RRDY);
    assign send_pmack = (lst == shlpc_pkg::SHLPC_L_PM_ACK);
    assign phy_partial_req = (lst == shlpc_pkg::SHLPC_L_PARTIAL);
    assign phy_slumber_req = (lst == shlpc_pkg::SHLPC_L_SLUMBER);
    assign link_state = lst;

    // ***********************************
    // Command completion coalescing
    // ***********************************
    logic [7:0] ccc_cnt;
    logic [7:0] next_ccc_cnt;
    logic next_ccc_irq;
    logic ccc_hit;

    // Clear wins: a completion in the clearing cycle is dropped, no interrupt
    always_comb begin
        ccc_hit = ccc_enable && cmd_complete
            && (ccc_cnt + 8'h01 >= ccc_threshold);
        next_ccc_irq = ccc_hit;
        next_ccc_cnt = ccc_cnt;
        if (!ccc_enable || ccc_hit) begin
            next_ccc_cnt = shlpc_pkg::CCC_RST;
        end else if (cmd_complete) begin
            next_ccc_cnt = ccc_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ccc_cnt <= shlpc_pkg::CCC_RST;
            ccc_irq <= 1'b0;
        end else begin
            ccc_cnt <= next_ccc_cnt;
            ccc_irq <= next_ccc_irq;
        end
    end

    assign ccc_count = ccc_cnt;

    // ***********************************
    // Descriptor-processed interrupt
    // ***********************************
    logic [15:0] prd_left;
    logic [15:0] next_prd_left;
    logic prd_active;
    logic next_prd_active;
    logic next_dps_irq;

    // Flag follows the last byte, not the first data FIS
    always_comb begin
        next_prd_left = prd_left;
        next_prd_active = prd_active;
        next_dps_irq = 1'b0;
        if (prd_start) begin
            next_prd_left = prd_bytes;
            next_prd_active = 1'b1;
        end else if (prd_active && data_fis_done) begin
            if (data_fis_bytes >= prd_left) begin
                next_prd_left = shlpc_pkg::PRD_RST;
                next_prd_active = 1'b0;
                next_dps_irq = 1'b1;
            end else begin
                next_prd_left = prd_left - data_fis_bytes;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prd_left <= shlpc_pkg::PRD_RST;
            prd_active <= 1'b0;
            dps_irq <= 1'b0;
        end else begin
            prd_left <= next_prd_left;
            prd_active <= next_prd_active;
            dps_irq <= next_dps_irq;
        end
    end

    // ***********************************
    // Write response shaping
    // ***********************************
    logic wr_pulse;

    // A level stretched by a FIFO clear still gives one pulse
    shlpc_pulse1 u_wrresp (
        .clk(clk),
        .rstn(rstn),
        .level(wrresp_raw),
        .pulse(wr_pulse)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrresp <= 1'b0;
        end else begin
            wrresp <= wr_pulse;
        end
    end

    // ***********************************
    // PHY power-down sequencer
    // ***********************************
    shlpc_pkg::shlpc_pwr_t pst;
    shlpc_pkg::shlpc_pwr_t next_pst;
    logic [7:0] wait_cnt;
    logic [7:0] next_wait_cnt;
    logic step;

    assign step = (wait_cnt == 8'h00);

    // Each stage settles before the next; only Slumber may start it
    always_comb begin
        next_pst = pst;
        next_wait_cnt = (wait_cnt == 8'h00) ? 8'h00 : wait_cnt - 8'h01;
        case (pst)
            shlpc_pkg::SHLPC_P_ON: begin
                if (sw_req_suspend && phy_slumber_req) begin
                    next_pst = shlpc_pkg::SHLPC_P_RX_OFF;
                    next_wait_cnt = shlpc_pkg::STEP_CNT;
                end
            end
            shlpc_pkg::SHLPC_P_RX_OFF: begin
                if (step) begin
                    next_pst = shlpc_pkg::SHLPC_P_TX_OFF;
                    next_wait_cnt = shlpc_pkg::STEP_CNT;
                end
            end
            shlpc_pkg::SHLPC_P_TX_OFF: begin
                if (step) begin
                    next_pst = shlpc_pkg::SHLPC_P_MPLL_OFF;
                    next_wait_cnt = shlpc_pkg::STEP_CNT;
                end
            end
            shlpc_pkg::SHLPC_P_MPLL_OFF: begin
                if (step) begin
                    next_pst = shlpc_pkg::SHLPC_P_CK_OFF;
                    next_wait_cnt = shlpc_pkg::STEP_CNT;
                end
            end
            shlpc_pkg::SHLPC_P_CK_OFF: begin
                if (step) begin
                    next_pst = shlpc_pkg::SHLPC_P_DONE;
                end
            end
            shlpc_pkg::SHLPC_P_DONE: begin
                if (!sw_req_suspend) begin
                    next_pst = shlpc_pkg::SHLPC_P_ON; // Resume by software
                end
            end
            default: begin
                next_pst = shlpc_pkg::SHLPC_P_ON;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pst <= shlpc_pkg::SHLPC_P_ON;
            wait_cnt <= 8'h00;
            phy_pd <= '0;
        end else begin
            pst <= next_pst;
            wait_cnt <= next_wait_cnt;
            phy_pd.rx_pd <= (next_pst != shlpc_pkg::SHLPC_P_ON);
            phy_pd.tx_pd <= (next_pst == shlpc_pkg::SHLPC_P_TX_OFF)
                || (next_pst == shlpc_pkg::SHLPC_P_MPLL_OFF)
                || (next_pst == shlpc_pkg::SHLPC_P_CK_OFF)
                || (next_pst == shlpc_pkg::SHLPC_P_DONE);
            phy_pd.mpll_pd <= (next_pst == shlpc_pkg::SHLPC_P_MPLL_OFF)
                || (next_pst == shlpc_pkg::SHLPC_P_CK_OFF)
                || (next_pst == shlpc_pkg::SHLPC_P_DONE);
            phy_pd.refclk_off_control <=
                (next_pst == shlpc_pkg::SHLPC_P_CK_OFF)
                || (next_pst == shlpc_pkg::SHLPC_P_DONE);
        end
    end

    assign pd_done = (pst == shlpc_pkg::SHLPC_P_DONE);
endmodule // shlpc_top
`default_nettype wire

// ### shlpc_top_chk.sv
// Checker for the host link power control top; bound below.
// Assumes one clock domain and the registered answers of the block.
`timescale 1ns/10ps
`default_nettype none
module shlpc_top_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire shlpc_pkg::shlpc_link_ev_t link_ev,
    input wire logic pm_nak,
    input wire logic ccc_enable,
    input wire logic [7:0] ccc_threshold,
    input wire logic cmd_complete,
    input wire logic data_fis_done,
    input wire logic wrresp_raw,
    input wire logic send_xrdy,
    input wire logic send_rrdy,
    input wire logic send_pmack,
    input wire logic phy_partial_req,
    input wire logic phy_slumber_req,
    input wire logic [5:0] link_state,
    input wire logic ccc_irq,
    input wire logic [7:0] ccc_count,
    input wire logic dps_irq,
    input wire logic wrresp,
    input wire shlpc_pkg::shlpc_phy_pd_t phy_pd
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic idle = link_state == 6'h01;
    sequence s_srst;
        idle && link_ev.soft_reset && !link_ev.rx_xrdy;
    endsequence
    sequence s_pm;
        idle && link_ev.rx_pmreq_partial && link_ev[4:3] == 2'h0
            && !link_ev.soft_reset;
    endsequence
    sequence s_wr_rise;
        !wrresp_raw ##1 wrresp_raw;
    endsequence
    // Each step is one settle time plus one cycle after the last
    sequence s_pd_steps;
        phy_pd == 4'h8 ##11 phy_pd == 4'hc ##11 phy_pd == 4'he
            ##11 phy_pd == 4'hf;
    endsequence
    AST_TX_WINS: assert property (idle && link_ev == 5'h12 |=>
        send_xrdy && !send_pmack) else $error("slumber beat tx data");
    AST_ONE_MODE: assert property (!(phy_partial_req && phy_slumber_req)
        && (link_state != 6'h10 || phy_partial_req))
        else $error("wrong power mode output");
    AST_PARTIAL_ONLY: assert property (s_pm ##1 (send_pmack
        && !pm_nak && !link_ev.soft_reset) |=> phy_partial_req
        && !phy_slumber_req) else $error("partial gave wrong mode");
    AST_CCC_WRAP: assert property (ccc_enable && cmd_complete &&
        9'(ccc_count) + 9'h001 >= 9'(ccc_threshold) |=>
        ccc_irq && ccc_count == 8'h00) else $error("coalescing wrap");
    AST_CCC_CLR: assert property (!ccc_enable |=>
        ccc_count == 8'h00 && !ccc_irq) else $error("clear lost");
    AST_DPS_CAUSE: assert property (dps_irq |-> $past(data_fis_done))
        else $error("dps without fis end");
    AST_WR_ONE: assert property (s_wr_rise |=> wrresp ##1 !wrresp)
        else $error("write response width");
    AST_RRDY: assert property (idle && link_ev.rx_xrdy |=> send_rrdy)
        else $error("no R_RDY");
    AST_SRST_IDLE: assert property (s_srst |=> idle)
        else $error("soft reset left idle");
    AST_PM_AFTER_SRST: assert property (s_srst ##1 s_pm |=> send_pmack)
        else $error("stuck after soft reset");
    AST_PD_SLUMBER: assert property ($rose(phy_pd.rx_pd) |->
        $past(phy_slumber_req)) else $error("power down not from slumber");
    AST_PD_ORDER: assert property ($rose(phy_pd.rx_pd) |-> s_pd_steps)
        else $error("power down order");
endmodule // shlpc_top_chk
bind shlpc_top shlpc_top_chk i_chk (.clk(clk), .rstn(rstn),
    .link_ev(link_ev), .pm_nak(pm_nak), .ccc_enable(ccc_enable),
    .ccc_threshold(ccc_threshold),
    .cmd_complete(cmd_complete), .data_fis_done(data_fis_done),
    .wrresp_raw(wrresp_raw), .send_xrdy(send_xrdy), .send_rrdy(send_rrdy),
    .send_pmack(send_pmack), .phy_partial_req(phy_partial_req),
    .phy_slumber_req(phy_slumber_req), .link_state(link_state),
    .ccc_irq(ccc_irq), .ccc_count(ccc_count), .dps_irq(dps_irq),
    .wrresp(wrresp), .phy_pd(phy_pd));
`default_nettype wire

// ### tb.sv
// Self-checking bench for the host link power control top.
// Assumes the drive model answers the link side; all else driven here.
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [2:0] want;
        logic tx;
        logic srst;
        logic [2:0] exp_send;
        logic [1:0] exp_mode;
    } shlpc_row_t;
    localparam int STEP = shlpc_pkg::STEP_CYC + 1;
    localparam int RESUME_CYC = 10000; // 100 us software wait at 10 ns
    logic clk, rstn, tx, srst, nak, susp, ccc_en, cmd, prd_go, fis, raw;
    logic [2:0] want;
    logic [7:0] thr, cnt;
    logic [15:0] prd_len, fis_len;
    logic rq_x, rq_p, rq_s, pm_nak, s_x, s_r, s_pm, m_p, m_s;
    logic ccc_irq, dps_irq, wrresp, pd_done;
    logic [5:0] st;
    shlpc_pkg::shlpc_phy_pd_t pd;
    shlpc_pkg::shlpc_link_ev_t ev;
    int num_errors, comparisons, n_ccc, n_dps, n_wr;
    // Rows: want{x,p,s}, tx, srst, send{x,r,pm}, mode{p,s}
    shlpc_row_t rows [7] = '{'{3'h0, 1'h1, 1'h0, 3'h4, 2'h0},
        '{3'h4, 1'h0, 1'h0, 3'h2, 2'h0}, '{3'h1, 1'h0, 1'h0, 3'h1, 2'h1},
        '{3'h1, 1'h1, 1'h0, 3'h4, 2'h0}, '{3'h2, 1'h0, 1'h0, 3'h1, 2'h2},
        '{3'h4, 1'h0, 1'h1, 3'h2, 2'h0}, '{3'h0, 1'h0, 1'h1, 3'h0, 2'h0}};
    assign ev = {tx, rq_x, rq_p, rq_s, srst};
    shlpc_drive_model i_drive (.clk(clk), .rstn(rstn), .want(want),
        .nak_mode(nak), .send_xrdy(s_x), .send_rrdy(s_r), .send_pmack(s_pm),
        .rx_xrdy(rq_x), .rx_pmreq_partial(rq_p), .rx_pmreq_slumber(rq_s),
        .pm_nak(pm_nak));
    shlpc_top i_dut (.clk(clk), .rstn(rstn), .link_ev(ev), .pm_nak(pm_nak),
        .sw_req_suspend(susp), .ccc_enable(ccc_en), .ccc_threshold(thr),
        .cmd_complete(cmd), .prd_start(prd_go), .prd_bytes(prd_len),
        .data_fis_done(fis), .data_fis_bytes(fis_len), .wrresp_raw(raw),
        .send_xrdy(s_x), .send_rrdy(s_r), .send_pmack(s_pm),
        .phy_partial_req(m_p), .phy_slumber_req(m_s), .link_state(st),
        .ccc_irq(ccc_irq), .ccc_count(cnt), .dps_irq(dps_irq),
        .wrresp(wrresp), .phy_pd(pd), .pd_done(pd_done));
    // ****************
    // Helpers
    // ****************
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // Pulse counters sample on the falling edge, away from updates
    always @(negedge clk) begin
        n_ccc += (ccc_irq === 1'h1);
        n_dps += (dps_irq === 1'h1);
        n_wr += (wrresp === 1'h1);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog; tests need about 20100 cycles, mostly resume waits
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        print_verdict;
    end
    // ****************
    // Tests
    // ****************
    initial begin
        {rstn, tx, srst, nak, susp, ccc_en, cmd, prd_go, fis, raw} = 10'h000;
        {want, thr, prd_len, fis_len} = 43'h000_0000_0000;
        repeat (6) @(posedge clk);
        #1 rstn = 1'h1;
        for (int i = 0; i < 7; i++) begin
            {want, tx, srst} = {rows[i].want, rows[i].tx, rows[i].srst};
            cyc(1);
            {want, tx, srst} = 5'h00;
            chk({s_x, s_r, s_pm}, rows[i].exp_send); // answer
            cyc(1);
            chk({m_p, m_s}, rows[i].exp_mode); // mode
            srst = 1'h1;
            cyc(1);
            srst = 1'h0;
            chk(st, 6'h01); // back to idle
        end
        // Soft reset beside a drive request, then a refused Partial
        {srst, want, nak} = 5'h15;
        cyc(1);
        {srst, want} = 4'h0;
        chk(st, 6'h01); // idle
        cyc(1);
        chk(s_pm, 1'h1); // request still answered
        cyc(1);
        chk({m_p, st}, 7'h01); // nak drops to idle
        nak = 1'h0;
        $display("link tests done");
        // Completion burst past the threshold, then clear with completion
        {ccc_en, thr, cmd} = 10'h207;
        cyc(4);
        cmd = 1'h0;
        cyc(1);
        chk({n_ccc[7:0], cnt}, 16'h0101); // one irq, one left
        {ccc_en, cmd} = 2'h1;
        cyc(1);
        {ccc_en, cmd} = 2'h2;
        cyc(2);
        chk({n_ccc[7:0], cnt}, 16'h0100); // folded, no irq
        // One PRD over two data FISes
        {prd_go, prd_len, fis_len} = 33'h1_0400_0200;
        cyc(1);
        {prd_go, fis} = 2'h1;
        cyc(1);
        fis = 1'h0;
        cyc(2);
        chk(n_dps, 0); // not after first FIS
        fis = 1'h1;
        cyc(1);
        fis = 1'h0;
        cyc(1);
        chk(n_dps, 1); // after whole PRD
        // Stretched then short raw write responses
        raw = 1'h1;
        cyc(5);
        raw = 1'h0;
        cyc(2);
        raw = 1'h1;
        cyc(2);
        raw = 1'h0;
        cyc(2);
        chk(n_wr, 2); // one cycle each
        $display("event tests done");
        // Suspend from idle does nothing; from Slumber runs the sequence
        susp = 1'h1;
        cyc(15);
        chk(pd, 4'h0); // no sequence
        want = 3'h1;
        cyc(1);
        want = 3'h0;
        cyc(2);
        for (int k = 0; k < 4; k++) begin
            chk(pd, 4'(4'hf << (3 - k))); // step order
            cyc(STEP);
        end
        chk(pd_done, 1'h1); // done after clock off
        susp = 1'h0;
        cyc(1);
        chk(pd, 4'h0); // resume clears
        cyc(RESUME_CYC); // Main PLL lock wait
        chk({pd, st}, 10'h020); // PHY up, link parked
        cyc(RESUME_CYC); // RX PLL lock wait
        chk(pd_done, 1'h0); // no new power-down
        $display("power down test done");
        // Reset in mid-run
        rstn = 1'h0;
        #2;
        chk({st, pd, cnt}, 18'h0_1000); // reset values
        cyc(2);
        rstn = 1'h1;
        want = 3'h4;
        cyc(1);
        want = 3'h0;
        chk(s_r, 1'h1); // answered at first edge after reset
        $display("reset test done");
        print_verdict;
    end
endmodule // tb
`default_nettype wire
